// ===== design/sesl_fmt.sv
`timescale 1ns/1ns
`include "sesl_map.svh"

module sesl_fmt
    import sesl_pkg::*;
(
    input  wire logic       ref_clk,   // clock
    input  wire logic       rst_n,     // async reset
    input  wire logic       start,     // load a value to send
    input  wire logic [7:0] value,     // value to format
    input  wire logic       ready,     // receiver takes a char
    output logic            valid,     // char offered
    output logic      [7:0] char_out,  // ascii digit
    output logic            last       // final digit of the number
);

    logic       [3:0] dig_h;
    logic       [3:0] dig_t;
    logic       [3:0] dig_o;
    sesl_pos_t        pos;

    function automatic logic [7:0] to_ascii(input logic [3:0] d);
        to_ascii = `SESL_ASCII_ZERO + {4'h0, d};
    endfunction

    function automatic logic [3:0] pick(input sesl_pos_t p, input logic [3:0] h,
                                        input logic [3:0] t, input logic [3:0] o);
        case (p)
            2'h2:    pick = h;
            2'h1:    pick = t;
            default: pick = o;
        endcase
    endfunction

    logic [3:0] in_h;
    logic [3:0] in_t;
    logic [3:0] in_o;
    sesl_pos_t  in_pos;

    always_comb
    begin
        in_h = 4'(value / 8'd100);
        in_t = 4'((value / 8'd10) % 8'd10);
        in_o = 4'(value % 8'd10);
        // no leading zeros; zero itself is one digit
        if (in_h != 4'h0)
            in_pos = 2'h2;
        else if (in_t != 4'h0)
            in_pos = 2'h1;
        else
            in_pos = 2'h0;
    end

    assign last = (pos == 2'h0);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid    <= 1'b0;
            char_out <= 8'h00;
            pos      <= 2'h0;
            dig_h    <= 4'h0;
            dig_t    <= 4'h0;
            dig_o    <= 4'h0;
        end
        else if (start && !valid)
        begin
            valid    <= 1'b1;
            dig_h    <= in_h;
            dig_t    <= in_t;
            dig_o    <= in_o;
            pos      <= in_pos;
            char_out <= to_ascii(pick(in_pos, in_h, in_t, in_o));
        end
        else if (valid && ready)
        begin
            if (last)
                valid <= 1'b0;
            else
            begin
                pos      <= pos - 2'h1;
                char_out <= to_ascii(pick(pos - 2'h1, dig_h, dig_t, dig_o));
            end
        end
    end

endmodule

// ===== design/sesl_map.svh
`ifndef SESL_MAP_SVH
`define SESL_MAP_SVH

// bit positions in the event register and its enable mask
`define SESL_BIT_PON        7
`define SESL_BIT_CME        5
`define SESL_BIT_EXE        4
`define SESL_BIT_DDE        3
`define SESL_BIT_QYE        2
`define SESL_BIT_OPC        0

// reset values and the mask of used event bits
`define SESL_ENABLE_RESET   8'h00
`define SESL_EVENT_RESET    8'h80
`define SESL_USED_MASK      8'hBD

// numeric limits and ascii codes
`define SESL_MASK_MAX       10'h0FF
`define SESL_ACC_LIMIT      10'h3E7
`define SESL_ASCII_ZERO     8'h30
`define SESL_ASCII_NINE     8'h39
`define SESL_ASCII_PLUS     8'h2B

`endif

// ===== design/sesl_pkg.sv
package sesl_pkg;

    typedef enum logic [1:0]
    {
        SESL_IDLE  = 2'b00,
        SESL_PARSE = 2'b01
    } sesl_parse_e;

    typedef logic [1:0] sesl_pos_t;

endpackage

// ===== design/sesl_top.sv
`timescale 1ns/1ns
`include "sesl_map.svh"

module sesl_top
    import sesl_pkg::*;
#(
    parameter int MASK_W = 8
)
(
    input  wire logic       ref_clk,         // 10 MHz clock
    input  wire logic       rst_n,           // async reset, power-on
    input  wire logic       cmd_cls,         // clear-status command strobe
    input  wire logic       cmd_cls_query,   // clear-status sent as query
    input  wire logic       cmd_ese,         // enable-mask command, parameter follows
    input  wire logic       cmd_ese_query,   // enable-mask query strobe
    input  wire logic       cmd_esr_query,   // event status query strobe
    input  wire logic       param_valid,     // parameter char strobe
    input  wire logic [7:0] param_char,      // parameter ascii char
    input  wire logic       param_last,      // final parameter char
    input  wire logic       ev_opc,          // operation complete event
    input  wire logic       ev_cme,          // command error event
    input  wire logic       ev_exe,          // execution error event
    input  wire logic       ev_dde,          // device-dependent error event
    input  wire logic       ev_qye,          // query error event
    input  wire logic       resp_ready,      // output side takes a char
    output logic            resp_valid,      // answer char offered
    output logic      [7:0] resp_char,       // answer ascii char
    output logic            resp_last,       // final char of answer
    output logic            event_summary,   // summary bit for status byte
    output logic            err_queue_clear, // flush error queue, pulse
    output logic            status_q_clear,  // flush status queues, pulse
    output logic            opc_cancel,      // cancel pending op-complete, pulse
    output logic      [7:0] event_enable_mask, // current enable mask
    output logic      [7:0] event_status     // current event register
);

    if (MASK_W != 8)
        $error("sesl_top: only an 8-bit mask is supported");
    // the decimal limit in the map must track the mask width
    if (`SESL_MASK_MAX != (10'h001 << MASK_W) - 10'h001)
        $error("sesl_top: mask limit does not match the mask width");

    sesl_parse_e       parse_st;
    logic        [9:0] acc;
    logic              acc_bad;
    logic              acc_ovf;
    logic              acc_first;

    logic              is_digit;
    logic        [9:0] next_acc;
    logic              next_ovf;
    logic              char_bad;
    logic              param_done;
    logic              param_cme;
    logic              param_exe;
    logic              fmt_start;
    logic        [7:0] fmt_value;
    logic              query_any;
    logic              query_clash;
    logic              esr_take;
    logic        [7:0] ev_in;
    logic        [7:0] next_event;

    // parameter digit accumulation
    always_comb
    begin
        is_digit = (param_char >= `SESL_ASCII_ZERO) && (param_char <= `SESL_ASCII_NINE);
        char_bad = !is_digit && !(acc_first && param_char == `SESL_ASCII_PLUS);
        next_acc = acc;
        next_ovf = acc_ovf;
        if (is_digit)
        begin
            // saturate well above the limit so a long string cannot wrap back into range
            if (acc > `SESL_ACC_LIMIT / 10'd10)
                next_ovf = 1'b1;
            else
                next_acc = 10'((acc * 10'd10) + {2'b00, param_char - `SESL_ASCII_ZERO});
        end
    end

    // a clear-status on the last char drops the whole parameter, errors included
    assign param_done = (parse_st == SESL_PARSE) && param_valid && param_last && !cmd_cls;
    assign param_cme  = param_done && (acc_bad || char_bad || (acc_first && !is_digit));
    assign param_exe  = param_done && !param_cme && (next_ovf || next_acc > `SESL_MASK_MAX);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            parse_st  <= SESL_IDLE;
            acc       <= 10'h000;
            acc_bad   <= 1'b0;
            acc_ovf   <= 1'b0;
            acc_first <= 1'b1;
        end
        else
        begin
            case (parse_st)
                SESL_IDLE:
                begin
                    if (cmd_ese)
                    begin
                        parse_st  <= SESL_PARSE;
                        acc       <= 10'h000;
                        acc_bad   <= 1'b0;
                        acc_ovf   <= 1'b0;
                        acc_first <= 1'b1;
                    end
                end
                SESL_PARSE:
                begin
                    if (cmd_cls)
                        parse_st <= SESL_IDLE;
                    else if (param_valid)
                    begin
                        acc       <= next_acc;
                        acc_ovf   <= next_ovf;
                        acc_bad   <= acc_bad || char_bad;
                        acc_first <= 1'b0;
                        if (param_last)
                            parse_st <= SESL_IDLE;
                    end
                end
                default:
                    parse_st <= SESL_IDLE;
            endcase
        end
    end

    // enable mask: only a clean parameter loads it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_enable_mask <= `SESL_ENABLE_RESET;
        else if (param_done && !param_cme && !param_exe && !cmd_cls)
            event_enable_mask <= next_acc[7:0];
    end

    // a query while an answer is still going out is a query error
    assign query_any   = cmd_ese_query || cmd_esr_query;
    assign query_clash = query_any && resp_valid;
    assign esr_take    = cmd_esr_query && !query_clash;

    always_comb
    begin
        ev_in                 = 8'h00;
        ev_in[`SESL_BIT_OPC]  = ev_opc;
        ev_in[`SESL_BIT_QYE]  = ev_qye || query_clash;
        ev_in[`SESL_BIT_DDE]  = ev_dde;
        ev_in[`SESL_BIT_EXE]  = ev_exe || param_exe;
        ev_in[`SESL_BIT_CME]  = ev_cme || param_cme || cmd_cls_query;
        // set wins over a clear in the same cycle
        if (cmd_cls || esr_take)
            next_event = ev_in;
        else
            next_event = event_status | ev_in;
        next_event = next_event & `SESL_USED_MASK;
        // bit 7 only ever comes from reset: no run-time event sets it
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_status <= `SESL_EVENT_RESET;
        else
            event_status <= next_event;
    end

    assign event_summary = |(event_status & event_enable_mask);

    // side effects of clear-status
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_queue_clear <= 1'b0;
            status_q_clear  <= 1'b0;
            opc_cancel      <= 1'b0;
        end
        else
        begin
            // pulses stand in the same cycle as the cleared register
            err_queue_clear <= cmd_cls;
            status_q_clear  <= cmd_cls;
            opc_cancel      <= cmd_cls;
        end
    end

    // esr query wins if both queries strobe together; value sampled before the clear
    assign fmt_start = query_any && !query_clash;
    assign fmt_value = cmd_esr_query ? event_status : event_enable_mask;

    sesl_fmt u_fmt
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (fmt_start),
        .value    (fmt_value),
        .ready    (resp_ready),
        .valid    (resp_valid),
        .char_out (resp_char),
        .last     (resp_last)
    );

endmodule

// ===== sim/sesl_ctrl_model.sv
`timescale 1ns/1ns
module sesl_ctrl_model
(
    input  wire logic       ref_clk,    // clock
    input  wire logic       stall,      // slow reader
    input  wire logic       resp_valid, // char offered
    input  wire logic [7:0] resp_char,  // ascii digit
    input  wire logic       resp_last,  // final digit
    output logic            resp_ready, // reader takes char
    output logic      [9:0] answer,     // last full number
    output int              n_ans       // answers seen
);
    logic       ready_q = 1'b1;
    logic [9:0] acc     = 10'h000;
    logic [9:0] ans_q   = 10'h000;
    int         cnt_q   = 0;
    logic [9:0] next_acc;
    assign resp_ready = ready_q;
    assign answer     = ans_q;
    assign n_ans      = cnt_q;
    assign next_acc   = 10'(acc * 10'h00A + 10'(resp_char - 8'h30));
    // slow mode takes a char only every other cycle
    always @(posedge ref_clk)
    begin
        ready_q <= stall ? !ready_q : 1'b1;
        if (resp_valid && ready_q)
        begin
            acc <= resp_last ? 10'h000 : next_acc;
            if (resp_last)
            begin
                ans_q <= next_acc;
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule

// ===== sim/sesl_top_properties.sv
`timescale 1ns/1ns
module sesl_top_chk
    import sesl_pkg::*;
#(
    parameter int MASK_W = 8
)
(
    input wire logic       ref_clk,           // clock
    input wire logic       rst_n,             // async reset
    input wire logic       cmd_cls,           // clear-status strobe
    input wire logic       cmd_cls_query,     // clear-status as query
    input wire logic       cmd_ese_query,     // mask query strobe
    input wire logic       cmd_esr_query,     // status query strobe
    input wire logic       param_valid,       // parameter char strobe
    input wire logic       param_last,        // final parameter char
    input wire logic       ev_opc,            // op complete event
    input wire logic       ev_cme,            // command error event
    input wire logic       ev_exe,            // execution error event
    input wire logic       ev_dde,            // device error event
    input wire logic       ev_qye,            // query error event
    input wire logic       resp_ready,        // reader takes char
    input wire logic       resp_valid,        // answer char offered
    input wire logic [7:0] resp_char,         // answer char
    input wire logic       event_summary,     // summary bit
    input wire logic       err_queue_clear,   // error queue flush
    input wire logic       status_q_clear,    // status queue flush
    input wire logic       opc_cancel,        // op complete cancel
    input wire logic [7:0] event_enable_mask, // enable mask
    input wire logic [7:0] event_status       // event register
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic quiet;
    assign quiet = !(ev_opc | ev_cme | ev_exe | ev_dde | ev_qye | param_valid | cmd_cls_query);
    property p_cls_clear; cmd_cls && quiet |=> event_status == 8'h00; endproperty
    a_cls_clear: assert property (p_cls_clear) else $error("status not cleared");
    property p_cls_pulse; cmd_cls |=> err_queue_clear && status_q_clear && opc_cancel; endproperty
    a_cls_pulse: assert property (p_cls_pulse) else $error("flush pulses missing");
    property p_cls_mask; cmd_cls |=> $stable(event_enable_mask); endproperty
    a_cls_mask: assert property (p_cls_mask) else $error("mask changed by clear");
    property p_mask_src; $changed(event_enable_mask) |-> $past(param_last) || $past(param_last, 2); endproperty
    a_mask_src: assert property (p_mask_src) else $error("mask changed without command");
    property p_summary; event_summary == |(event_status & event_enable_mask); endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");
    property p_unused; event_status[6] == 1'b0 && event_status[1] == 1'b0; endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    property p_esr_ans; cmd_esr_query && !resp_valid |=> resp_valid; endproperty
    a_esr_ans: assert property (p_esr_ans) else $error("no answer");
    property p_esr_clr; cmd_esr_query && !resp_valid && !cmd_cls && quiet |=> event_status == 8'h00; endproperty
    a_esr_clr: assert property (p_esr_clr) else $error("read did not clear");
    property p_latch; ev_cme ##1 (!cmd_cls && !cmd_esr_query) |-> event_status[5] [*2]; endproperty
    a_latch: assert property (p_latch) else $error("event not held");
    property p_cls_q; cmd_cls_query |=> event_status[5]; endproperty
    a_cls_q: assert property (p_cls_q) else $error("query form accepted");
    property p_hold; resp_valid && !resp_ready |=> resp_valid && $stable(resp_char); endproperty
    a_hold: assert property (p_hold) else $error("answer dropped");
    property p_digit; resp_valid |-> resp_char inside {[8'h30:8'h39]}; endproperty
    a_digit: assert property (p_digit) else $error("non digit answer");
endmodule
bind sesl_top sesl_top_chk #(.MASK_W(MASK_W)) chk (.ref_clk, .rst_n, .cmd_cls, .cmd_cls_query, .cmd_ese_query,
    .cmd_esr_query, .param_valid, .param_last, .ev_opc, .ev_cme, .ev_exe, .ev_dde, .ev_qye, .resp_ready,
    .resp_valid, .resp_char, .event_summary, .err_queue_clear, .status_q_clear, .opc_cancel,
    .event_enable_mask, .event_status);

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import sesl_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
    logic cmd_cls = 1'b0, cmd_cls_query = 1'b0, cmd_ese = 1'b0, cmd_ese_query = 1'b0, cmd_esr_query = 1'b0;
    logic param_valid = 1'b0, param_last = 1'b0;
    logic [7:0] param_char = 8'h00;
    logic [4:0] ev = 5'h00;
    logic resp_ready, resp_valid, resp_last, event_summary, err_queue_clear, status_q_clear, opc_cancel;
    logic [7:0] resp_char, event_enable_mask, event_status;
    logic [9:0] answer;
    int n_ans, mismatches = 0, check_count = 0;
    sesl_top dut (.ref_clk, .rst_n, .cmd_cls, .cmd_cls_query, .cmd_ese, .cmd_ese_query, .cmd_esr_query,
        .param_valid, .param_char, .param_last, .ev_opc(ev[0]), .ev_cme(ev[4]), .ev_exe(ev[3]), .ev_dde(ev[2]),
        .ev_qye(ev[1]), .resp_ready, .resp_valid, .resp_char, .resp_last, .event_summary, .err_queue_clear,
        .status_q_clear, .opc_cancel, .event_enable_mask, .event_status);
    sesl_ctrl_model ctrl (.ref_clk, .stall, .resp_valid, .resp_char, .resp_last, .resp_ready, .answer, .n_ans);
    initial forever #50 ref_clk = !ref_clk;
    task report_and_stop;
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task ask(input bit esr, input logic [9:0] exp);
        int n;
        n = n_ans;
        @(posedge ref_clk) if (esr) cmd_esr_query <= 1'b1; else cmd_ese_query <= 1'b1;
        @(posedge ref_clk) {cmd_esr_query, cmd_ese_query} <= 2'b00;
        repeat (40) if (n_ans == n) @(posedge ref_clk);
        check(10'(n_ans - n), 10'h001);
        check(answer, exp);
    endtask
    task ese_write(input string s);
        @(posedge ref_clk) cmd_ese <= 1'b1;
        for (int i = 0; i < s.len(); i++)
        begin
            @(posedge ref_clk) cmd_ese <= 1'b0;
            param_valid <= 1'b1;
            param_char <= s[i];
            param_last <= (i == s.len() - 1);
        end
        @(posedge ref_clk) {param_valid, param_last} <= 2'b00;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task pulse_ev(input logic [4:0] v);
        @(posedge ref_clk) ev <= v;
        @(posedge ref_clk) ev <= 5'h00;
        @(negedge ref_clk);
    endtask
    task t_reset;
        @(negedge ref_clk);
        check(10'(event_enable_mask), 10'h000);
        check(10'(event_status), 10'h080);
        ask(1'b1, 10'h080);
        ask(1'b1, 10'h000);
    endtask
    task t_mask;
        ese_write("+32");
        check(10'(event_enable_mask), 10'h020);
        ask(1'b0, 10'h020);
        pulse_ev(5'h10);
        check(10'(event_summary), 10'h001);
        ese_write("16");
        check(10'(event_summary), 10'h000);
        ese_write("256");
        check(10'(event_enable_mask), 10'h010);
        check(10'(event_status[4]), 10'h001);
        ese_write("255");
        ask(1'b0, 10'h0FF);
    endtask
    task t_esr_slow;
        pulse_ev(5'h1F);
        stall <= 1'b1;
        ask(1'b1, 10'h03D);
        stall <= 1'b0;
    endtask
    task t_cls;
        int n;
        pulse_ev(5'h15);
        @(posedge ref_clk) cmd_cls <= 1'b1;
        @(posedge ref_clk) cmd_cls <= 1'b0;
        @(negedge ref_clk);
        check(10'({err_queue_clear, status_q_clear, opc_cancel}), 10'h007);
        check(10'(event_status), 10'h000);
        check(10'(event_enable_mask), 10'h0FF);
        n = n_ans;
        @(posedge ref_clk) cmd_cls_query <= 1'b1;
        @(posedge ref_clk) cmd_cls_query <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(10'(n_ans - n), 10'h000);
        check(10'(event_status[5]), 10'h001);
        ese_write("0");
        ask(1'b0, 10'h000);
    endtask
    task t_errors;
        int n;
        ask(1'b1, 10'h020);
        ese_write("4x");
        ask(1'b1, 10'h020);
        ese_write("+");
        ask(1'b1, 10'h020);
        check(10'(event_enable_mask), 10'h000);
        @(posedge ref_clk) cmd_ese <= 1'b1;
        @(posedge ref_clk) {cmd_ese, param_valid, param_char} <= {2'b01, 8'h37};
        @(posedge ref_clk) {cmd_cls, param_last, param_char} <= {2'b11, 8'h78};
        @(posedge ref_clk) {cmd_cls, param_valid, param_last} <= 3'b000;
        @(negedge ref_clk);
        check(10'(event_enable_mask), 10'h000);
        check(10'(event_status), 10'h000);
        ese_write("128");
        n = n_ans;
        @(posedge ref_clk) {cmd_esr_query, cmd_ese_query} <= 2'b11;
        @(posedge ref_clk) cmd_esr_query <= 1'b0;
        @(posedge ref_clk) cmd_ese_query <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(10'(n_ans - n), 10'h001);
        check(answer, 10'h000);
        check(10'(event_status), 10'h004);
        check(10'(event_summary), 10'h000);
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mask();
        t_esr_slow();
        t_cls();
        t_errors();
        report_and_stop();
    end
    initial
    begin
        #(100 * 3000);
        mismatches++;
        report_and_stop();
    end
endmodule
